// ===== hw/sep_top.sv
// Target-side core of a 4096 x 8 two-wire serial EEPROM with select straps.
//
// How it works
// - Answer only when the received select bits equal the three strap levels.
// - Three straps give eight unique addresses sharing one bus.
// - Every incoming bit is captured on the serial clock rising edge.
// - Outgoing bits change only after a serial clock falling edge.
// - The data line is only pulled low or released.
// - Write protect high blocks every array write; low lets writes proceed.
// - Undriven straps and write protect read as low; the core has no pull-downs and relies on ones outside.
// - The array holds 4096 bytes addressed by a 12-bit pointer.
// - Page writes take one to 32 consecutive bytes.
// - After a write stop, a self-timed cycle finishes within 5 ms.
// - Random reads and sequential reads from incrementing addresses.
`timescale 1ns/1ns
`default_nettype none
module sep_top #(
  parameter int WR_CYCLES = sep_pkg::WR_CYCLES,
  parameter logic [3:0] DEV_TYPE = sep_pkg::DEV_TYPE_DEFAULT
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic strap_select_bit0_in,
  input wire logic strap_select_bit1_in,
  input wire logic strap_select_bit2_in,
  input wire logic write_protect_in,
  output logic write_busy_out
);
  import sep_pkg::*;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rst_pipe;
  logic rst_n;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];

  // ****************************************************************
  // Pin and link crossings
  // ****************************************************************
  logic [SY_W-1:0] sy_d;
  logic [SY_W-1:0] sy_q;
  logic rx_bit;
  logic tx_low_req;

  sep_link u_link (
    .scl_in(scl_in),
    .rst_n_in(rst_n),
    .sda_in(sda_in),
    .tx_low_in(tx_low_req),
    .rx_bit_out(rx_bit),
    .sda_out(sda_out),
    .sda_oe_out(sda_oe_out)
  );

  // straps reset low
  // Floating pads are pulled down outside, and the synchroniser resets
  // to zero, so an unstrapped part selects address zero and is writable.
  assign sy_d = {rx_bit, strap_select_bit2_in, strap_select_bit1_in,
                 strap_select_bit0_in, write_protect_in, sda_in, scl_in};

  sep_sync #(
    .W(SY_W)
  ) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .d_in(sy_d),
    .q_out(sy_q)
  );

  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic rx_s;
  logic [DEV_SEL_W-1:0] strap_s;

  assign scl_s = sy_q[SY_SCL];
  assign sda_s = sy_q[SY_SDA];
  assign wp_s = sy_q[SY_WP];
  assign rx_s = sy_q[SY_RX];
  assign strap_s = sy_q[SY_STRAP0 +: DEV_SEL_W];

  // ****************************************************************
  // Core state
  // ****************************************************************
  localparam logic [TIMER_W-1:0] WR_LAST = TIMER_W'(WR_CYCLES - 1);

  typedef struct packed {
    sep_state_t st;
    logic scl_q;
    logic sda_q;
    logic [1:0] rise_d;
    logic [3:0] cnt;
    logic [DATA_W-1:0] shreg;
    logic first;
    logic [ADDR_W-1:0] addr;
    logic tx_low;
    logic [PAGE_BYTES-1:0] valid;
    logic got_data;
    logic busy;
    logic prog;
    logic [PAGE_W-1:0] prog_idx;
    logic [TIMER_W-1:0] timer;
  } sep_core_t;

  sep_core_t s;
  sep_core_t next_s;

  logic [DATA_W-1:0] mem [0:MEM_DEPTH-1];
  logic [DATA_W-1:0] pbuf [0:PAGE_BYTES-1];
  logic [DATA_W-1:0] mem_rd;
  logic pbuf_we;
  logic [DATA_W-1:0] byte_in;
  logic mem_we;
  logic rise_evt;
  logic start_c;
  logic stop_c;
  logic match;
  logic commit;

  // The read port is only used while no programming cycle runs, since the
  // part does not answer its address during one.
  assign mem_rd = mem[s.addr];
  assign byte_in = {s.shreg[DATA_W-2:0], rx_s};
  // The captured bit needs the same two flops as the clock copy, so the
  // edge is acted on two cycles late to be sure the bit has settled.
  assign rise_evt = s.rise_d[1];
  // start and stop need a high idle clock
  assign start_c = scl_s & s.scl_q & s.sda_q & ~sda_s;
  assign stop_c = scl_s & s.scl_q & ~s.sda_q & sda_s;
  assign match = (byte_in[DEV_TYPE_LSB +: DEV_TYPE_W] == DEV_TYPE) &&
                 (byte_in[DEV_SEL_LSB +: DEV_SEL_W] == strap_s);
  assign commit = stop_c && (s.st == ST_WDATA) && s.got_data && !s.busy;

  always_comb begin
    next_s = s;
    pbuf_we = 1'b0;
    mem_we = 1'b0;
    next_s.scl_q = scl_s;
    next_s.sda_q = sda_s;
    next_s.rise_d = {s.rise_d[0], scl_s & ~s.scl_q};

    if (s.prog) begin
      mem_we = s.valid[s.prog_idx];
      next_s.prog_idx = s.prog_idx + 5'h01;
      if (s.prog_idx == 5'h1f) begin
        next_s.prog = 1'b0;
      end
    end
    if (s.busy) begin
      next_s.timer = s.timer + 16'h0001;
      if (s.timer == WR_LAST) begin
        next_s.busy = 1'b0;
        next_s.valid = '0;
      end
    end

    if (start_c) begin
      next_s.st = ST_DEV;
      next_s.cnt = 4'h0;
      next_s.tx_low = 1'b0;
      next_s.first = 1'b0;
      if (!s.busy) begin
        next_s.valid = '0;
        next_s.got_data = 1'b0;
      end
    end else if (stop_c) begin
      next_s.st = ST_IDLE;
      next_s.tx_low = 1'b0;
      next_s.got_data = 1'b0;
      if (commit) begin
        if (!wp_s) begin
          next_s.busy = 1'b1;
          next_s.prog = 1'b1;
          next_s.prog_idx = '0;
          next_s.timer = '0;
        end else begin
          next_s.valid = '0;
        end
      end
    end else if (rise_evt && (s.st != ST_IDLE)) begin
      if (s.cnt == ACK_SLOT) begin
        next_s.cnt = 4'h0;
        next_s.tx_low = 1'b0;
        if (s.st == ST_RDATA) begin
          if (s.first || !rx_s) begin
            next_s.first = 1'b0;
            next_s.shreg = mem_rd;
            next_s.tx_low = ~mem_rd[DATA_W-1];
          end else begin
            next_s.st = ST_IDLE;
          end
        end
      end else if (s.st == ST_RDATA) begin
        next_s.cnt = s.cnt + 4'h1;
        next_s.shreg = {s.shreg[DATA_W-2:0], 1'b0};
        // next bit prepared for the fall
        next_s.tx_low = ~s.shreg[DATA_W-2];
        if (s.cnt == LAST_BIT) begin
          next_s.tx_low = 1'b0;
          // pointer wraps over the 4096 bytes
          next_s.addr = s.addr + 12'h001;
        end
      end else begin
        next_s.cnt = s.cnt + 4'h1;
        // bit taken from rising edge capture
        next_s.shreg = byte_in;
        if (s.cnt == LAST_BIT) begin
          next_s.tx_low = 1'b1;
          case (s.st)
            ST_DEV: begin
              if (match && !s.busy) begin
                next_s.first = byte_in[DEV_RW_BIT];
                next_s.st = byte_in[DEV_RW_BIT] ? ST_RDATA : ST_AHI;
              end else begin
                next_s.tx_low = 1'b0;
                next_s.st = ST_IDLE;
              end
            end
            ST_AHI: begin
              next_s.addr[ADDR_W-1 -: ADDR_HI_W] = byte_in[ADDR_HI_W-1:0];
              next_s.st = ST_ALO;
            end
            ST_ALO: begin
              next_s.addr[DATA_W-1:0] = byte_in;
              next_s.st = ST_WDATA;
            end
            ST_WDATA: begin
              // one byte of up to 32 queued
              pbuf_we = 1'b1;
              next_s.valid[s.addr[PAGE_W-1:0]] = 1'b1;
              next_s.got_data = 1'b1;
              next_s.addr = {s.addr[ADDR_W-1:PAGE_W],
                             s.addr[PAGE_W-1:0] + 5'h01};
            end
            default: begin
              next_s.tx_low = 1'b0;
              next_s.st = ST_IDLE;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Page buffer and array
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (pbuf_we) begin
      pbuf[s.addr[PAGE_W-1:0]] <= byte_in;
    end
  end

  // 4096 byte locations
  // One byte goes in per cycle at the start of the cycle; the rest of the
  // time is spent idle so the busy window keeps its full specified length.
  always_ff @(posedge clk_in) begin
    if (mem_we) begin
      mem[{s.addr[ADDR_W-1:PAGE_W], s.prog_idx}] <= pbuf[s.prog_idx];
    end
  end

  assign tx_low_req = s.tx_low;
  assign write_busy_out = s.busy;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n);

  sequence dev_byte_end;
    rise_evt && (s.st == ST_DEV) && (s.cnt == LAST_BIT) && !start_c &&
    !stop_c;
  endsequence

  sequence page_byte_end;
    rise_evt && (s.st == ST_WDATA) && (s.cnt == LAST_BIT) && !start_c &&
    !stop_c;
  endsequence

  sequence read_byte_end;
    rise_evt && (s.st == ST_RDATA) && (s.cnt == LAST_BIT) && !start_c &&
    !stop_c;
  endsequence

  a_select_mismatch: assert property (
    dev_byte_end and !match |=> (s.st == ST_IDLE) && !s.tx_low)
    else $error("mismatched select byte was answered");

  a_select_ack: assert property (
    dev_byte_end and match && !s.busy |=> s.tx_low ##1 (s.cnt == ACK_SLOT))
    else $error("matching select byte not acknowledged");

  a_launch_timing: assert property (
    $changed(s.tx_low) |-> $past(rise_evt || start_c || stop_c))
    else $error("data launch request changed outside rise handling");

  a_open_drain: assert property (
    !sda_out and ((s.st == ST_IDLE) && $past(s.st == ST_IDLE) |-> !s.tx_low))
    else $error("data line driven high or held while idle");

  a_protect_blocks: assert property (
    commit && wp_s |=> !s.busy [*3])
    else $error("protected write started a cycle");

  a_write_starts: assert property (
    commit && !wp_s |=> s.busy && s.prog && (s.timer == '0))
    else $error("write cycle did not start after stop");

  a_cycle_length: assert property (
    $fell(s.busy) |-> $past(s.timer) == WR_LAST)
    else $error("write cycle length wrong");

  a_page_wrap: assert property (
    page_byte_end |=> (s.addr[ADDR_W-1:PAGE_W] ==
      $past(s.addr[ADDR_W-1:PAGE_W])) &&
      (s.addr[PAGE_W-1:0] == $past(s.addr[PAGE_W-1:0]) + 5'h01))
    else $error("page write pointer left its page");

  a_read_advance: assert property (
    read_byte_end |=> (s.addr == $past(s.addr) + 12'h001) && !s.tx_low)
    else $error("sequential read pointer did not advance");

  a_array_guard: assert property (
    mem_we |-> s.busy && s.prog && !$past(commit && wp_s))
    else $error("array written outside a permitted cycle");

endmodule
`default_nettype wire

// ===== hw/sep_pkg.sv
// Shared constants and types for the serial EEPROM select and protect block.
package sep_pkg;

  // ****************************************************************
  // Array and page geometry
  // ****************************************************************
  localparam int MEM_DEPTH = 4096;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_W = 5;
  localparam int ADDR_HI_W = 4;

  // ****************************************************************
  // Device select byte layout
  // ****************************************************************
  localparam int DEV_RW_BIT = 0;
  localparam int DEV_SEL_LSB = 1;
  localparam int DEV_SEL_W = 3;
  localparam int DEV_TYPE_LSB = 4;
  localparam int DEV_TYPE_W = 4;
  // The type nibble value is arbitrary; the bus controller must use the same.
  localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h5;

  // ****************************************************************
  // Bit slots within one nine-clock byte frame
  // ****************************************************************
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // ****************************************************************
  // Write cycle timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_WR_MS = 5;
  localparam int WR_CYCLES = (T_WR_MS * 1000000) / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;

  // ****************************************************************
  // Synchroniser lane positions
  // ****************************************************************
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_WP = 2;
  localparam int SY_STRAP0 = 3;
  localparam int SY_RX = 6;
  localparam int SY_W = 7;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_AHI,
    ST_ALO,
    ST_WDATA,
    ST_RDATA
  } sep_state_t;

endpackage

// ===== hw/sep_sync.sv
// Two-flop synchroniser for a bundle of independent level signals.
`timescale 1ns/1ns
`default_nettype none
module sep_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sep_sync_state_t;

  sep_sync_state_t s;
  sep_sync_state_t next_s;

  // The first stage feeds only the second; nothing else reads it.
  always_comb begin
    next_s.meta = d_in;
    next_s.q = s.meta;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q_out = s.q;

endmodule
`default_nettype wire

// ===== hw/sep_link.sv
// Serial clock domain: data capture on the rising edge, launch on the fall.
`timescale 1ns/1ns
`default_nettype none
module sep_link (
  input wire logic scl_in,
  input wire logic rst_n_in,
  input wire logic sda_in,
  input wire logic tx_low_in,
  output logic rx_bit_out,
  output logic sda_out,
  output logic sda_oe_out
);

  typedef struct packed {
    logic rx_bit;
  } sep_rx_t;

  typedef struct packed {
    logic pull_low;
    logic level;
  } sep_tx_t;

  sep_rx_t rx;
  sep_rx_t next_rx;
  sep_tx_t tx;
  sep_tx_t next_tx;

  // The two edges own separate state, so each half keeps one driver.
  always_comb begin
    next_rx.rx_bit = sda_in;
    next_tx.pull_low = tx_low_in;
    next_tx.level = 1'b0;
  end

  always_ff @(posedge scl_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx <= '0;
    end else begin
      rx <= next_rx;
    end
  end

  // The request is held steady by the core from the rising edge processing
  // until after this fall, so it is a quasi-static word, not a race.
  always_ff @(negedge scl_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx <= '0;
    end else begin
      tx <= next_tx;
    end
  end

  assign rx_bit_out = rx.rx_bit;
  assign sda_out = tx.level;
  assign sda_oe_out = tx.pull_low;

endmodule
`default_nettype wire

// ===== testbench/sep_ctl_model.sv
// Behavioural two-wire bus controller that drives the serial clock.
`timescale 1ns/1ns
`default_nettype none
module sep_ctl_model (
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out
);
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  // data moves while low.
  // The odd 6 ns in the low phase keeps the serial clock off the core grid.
  task automatic bit_x(input logic v, output logic s);
    #500 sda_oe_out = ~v;
    #1006 scl_out = 1'b1;
    #1002 s = sda_in;
    scl_out = 1'b0;
  endtask

  task automatic start();
    #500 sda_oe_out = 1'b0;
    #1000 scl_out = 1'b1;
    #1000 sda_oe_out = 1'b1;
    #1000 scl_out = 1'b0;
  endtask

  task automatic stop();
    #500 sda_oe_out = 1'b1;
    #1000 scl_out = 1'b1;
    #1000 sda_oe_out = 1'b0;
    #1500;
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], s);
    end
    bit_x(1'b1, s);
    ack = ~s;
  endtask

  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      d[i] = s;
    end
    bit_x(nack, s);
  endtask
endmodule
`default_nettype wire

// ===== testbench/sep_top_tb.sv
// Self-checking bench for the serial EEPROM select and protect block.
`timescale 1ns/1ns
`default_nettype none
module sep_top_tb;
  import sep_pkg::*;
  // Long enough that a select probe lands inside the write cycle.
  localparam int WR = 400;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic scl;
  logic sda;
  logic dut_out;
  logic dut_oe;
  logic ctl_oe;
  logic [2:0] strap = 3'h0;
  logic wp = 1'b0;
  logic busy;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int busy_len = 0;

  // Pull-up wire: low whenever either side pulls it.
  assign sda = ~(dut_oe | ctl_oe);

  sep_top #(.WR_CYCLES(WR), .DEV_TYPE(DEV_TYPE_DEFAULT)) u_sep_top (
    .clk_in(clk), .resetn_in(resetn), .scl_in(scl), .sda_in(sda),
    .sda_out(dut_out), .sda_oe_out(dut_oe),
    .strap_select_bit0_in(strap[0]), .strap_select_bit1_in(strap[1]),
    .strap_select_bit2_in(strap[2]), .write_protect_in(wp),
    .write_busy_out(busy)
  );

  sep_ctl_model u_sep_ctl_model (
    .sda_in(sda), .scl_out(scl), .sda_oe_out(ctl_oe)
  );

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (busy === 1'b1) begin
      busy_len <= busy_len + 1;
    end
    if (cycles == 60000) begin
      errors++;
      final_report();
    end
  end

  always @(dut_oe) begin
    if (resetn) begin
      chk("oe_edge_scl", 8'(scl), 8'h00);
      chk("sda_out_low", 8'(dut_out), 8'h00);
    end
  end

  function automatic logic [7:0] sel_b(input logic [2:0] s, input logic rw);
    return {DEV_TYPE_DEFAULT, s, rw};
  endfunction

  task automatic set_ptr(input logic [11:0] a);
    logic k0, k1, k2;
    u_sep_ctl_model.start();
    u_sep_ctl_model.wr_byte(sel_b(strap, 1'b0), k0);
    u_sep_ctl_model.wr_byte({4'h0, a[11:8]}, k1);
    u_sep_ctl_model.wr_byte(a[7:0], k2);
    chk("ptr_ack", 8'({k0, k1, k2}), 8'h07);
  endtask

  task automatic t_read(input logic [11:0] a, input logic [7:0] e0,
                        input logic [7:0] e1);
    logic ack;
    logic [7:0] d;
    set_ptr(a);
    u_sep_ctl_model.start();
    u_sep_ctl_model.wr_byte(sel_b(strap, 1'b1), ack);
    chk("rd_sel_ack", 8'(ack), 8'h01);
    u_sep_ctl_model.rd_byte(1'b0, d);
    chk("rd_first", d, e0);
    u_sep_ctl_model.rd_byte(1'b1, d);
    chk("rd_next", d, e1);
    u_sep_ctl_model.stop();
  endtask

  // Read probes are used so an acked select never starts a write cycle.
  task automatic t_select();
    logic ack;
    logic [7:0] d;
    for (int s = 0; s < 8; s++) begin
      @(posedge clk) #1 strap = 3'(s);
      repeat (4) @(posedge clk);
      for (int k = 0; k < 8; k++) begin
        u_sep_ctl_model.start();
        u_sep_ctl_model.wr_byte(sel_b(3'(k), 1'b1), ack);
        u_sep_ctl_model.rd_byte(1'b1, d);
        u_sep_ctl_model.stop();
        chk("sel_ack", 8'(ack), 8'(s == k));
      end
    end
    u_sep_ctl_model.start();
    u_sep_ctl_model.wr_byte({~DEV_TYPE_DEFAULT, strap, 1'b1}, ack);
    u_sep_ctl_model.rd_byte(1'b1, d);
    u_sep_ctl_model.stop();
    chk("type_nack", 8'(ack), 8'h00);
  endtask

  task automatic t_page_write();
    logic [7:0] pat [4] = '{8'h5a, 8'hc3, 8'h81, 8'h7e};
    logic ack;
    int n;
    set_ptr(12'hffe);
    for (int i = 0; i < 4; i++) begin
      u_sep_ctl_model.wr_byte(pat[i], ack);
      chk("wr_ack", 8'(ack), 8'h01);
    end
    busy_len = 0;
    u_sep_ctl_model.stop();
    chk("busy_rise", 8'(busy), 8'h01);
    u_sep_ctl_model.start();
    u_sep_ctl_model.wr_byte(sel_b(strap, 1'b0), ack);
    u_sep_ctl_model.stop();
    chk("busy_nack", 8'(ack), 8'h00);
    n = 0;
    while (busy !== 1'b0 && n < 2 * WR) begin
      @(posedge clk);
      n++;
    end
    #1;
    chk("busy_fall", 8'(busy), 8'h00);
    chk("busy_len", 8'(busy_len == WR), 8'h01);
    t_read(12'hffe, 8'h5a, 8'hc3);
    t_read(12'hfe0, 8'h81, 8'h7e);
  endtask

  task automatic t_protect();
    logic ack;
    @(posedge clk) #1 wp = 1'b1;
    set_ptr(12'hfe0);
    u_sep_ctl_model.wr_byte(8'h00, ack);
    u_sep_ctl_model.stop();
    chk("wp_no_busy", 8'(busy), 8'h00);
    t_read(12'hfe0, 8'h81, 8'h7e);
    @(posedge clk) #1 wp = 1'b0;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (4) @(posedge clk);
    t_select();
    t_page_write();
    t_protect();
    final_report();
  end
endmodule
`default_nettype wire
